//--- shared/lcdw_pkg.sv
// package: constants and carrier types for the display ram write addressing block
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package lcdw_pkg;
  localparam int         COLS       = 40;
  localparam int         ROWS       = 4;
  localparam int         BYTE_W     = 8;
  localparam int         FIFO_DEPTH = 8;
  localparam logic [5:0] LAST_COL   = 6'h27;
  localparam logic [5:0] PTR_RST    = 6'h00;
  localparam logic [2:0] SUB_RST    = 3'h0;
  localparam logic [1:0] BANK0_ROW  = 2'h0;
  localparam logic [1:0] BANK1_ROW  = 2'h2;
  // columns written per byte, which is also the pointer increment
  localparam logic [3:0] STEP_STAT  = 4'h8;
  localparam logic [3:0] STEP_MUX2  = 4'h4;
  localparam logic [3:0] STEP_MUX3  = 4'h3;
  localparam logic [3:0] STEP_MUX4  = 4'h2;

  typedef enum logic [1:0] {
    LCDW_STATIC = 2'b00,
    LCDW_MUX2   = 2'b01,
    LCDW_MUX3   = 2'b10,
    LCDW_MUX4   = 2'b11
  } lcdw_mode_t;

  typedef enum logic {
    LCDW_IDLE  = 1'b0,
    LCDW_WRITE = 1'b1
  } lcdw_fsm_t;

  typedef logic [COLS-1:0][ROWS-1:0] lcdw_ram_t;

  typedef struct packed {
    logic       load_ptr;
    logic [5:0] ptr_value;
    logic       dev_sel;
    logic [2:0] subaddr;
    logic       bank_sel;
    logic       in_bank;
    logic       out_bank;
  } lcdw_cmd_t;
endpackage

//--- logic/lcdw_fifo.sv
// fifo: byte buffer between the command receiver and the ram writer
`timescale 1ns/1ps
module lcdw_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock, reset, enable
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } lcdw_fifo_st_t;

  lcdw_fifo_st_t st;
  lcdw_fifo_st_t next_st;
  logic          push;
  logic          pop;

  // depth must be a power of two so the pointers wrap by themselves
  assign in_ready  = (st.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st.cnt != '0);
  assign out_data  = st.mem[st.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr] = in_data;
      next_st.wr         = st.wr + AW'(1);
    end
    if (pop) begin
      next_st.rd = st.rd + AW'(1);
    end
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end
endmodule

//--- logic/lcdw_outsel.sv
// output row selector: picks the ram row that feeds the display register
`timescale 1ns/1ps
module lcdw_outsel (
  // configuration
  input  wire lcdw_pkg::lcdw_mode_t    mode,
  input  wire logic                    out_bank,
  input  wire logic [1:0]              phase,
  // ram image
  input  wire lcdw_pkg::lcdw_ram_t     ram,
  // selected row
  output logic [1:0]                   row_sel,
  output logic [lcdw_pkg::COLS-1:0]    seg_row
);
  logic [1:0] base;

  // banks exist only in static and 1:2
  assign base = out_bank ? lcdw_pkg::BANK1_ROW : lcdw_pkg::BANK0_ROW;

  always_comb begin
    case (mode)
      lcdw_pkg::LCDW_STATIC: row_sel = base;
      lcdw_pkg::LCDW_MUX2:   row_sel = base | {1'b0, phase[0]};
      lcdw_pkg::LCDW_MUX3:   row_sel = (phase == 2'h3) ? 2'h0 : phase;
      lcdw_pkg::LCDW_MUX4:   row_sel = phase;
      default:               row_sel = 2'h0;
    endcase
  end

  for (genvar c = 0; c < lcdw_pkg::COLS; c++) begin : g_col
    assign seg_row[c] = ram[c][row_sel];
  end
endmodule

//--- logic/lcdw_ram_writer.sv
// display ram write addressing with pointer, subaddress counter and banks
`timescale 1ns/1ps
module lcdw_ram_writer (
  // clock, reset, enable
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic                     ce,
  // decoded commands from the bus receiver
  input  wire lcdw_pkg::lcdw_cmd_t      cmd,
  input  wire lcdw_pkg::lcdw_mode_t     drive_mode,
  // display byte stream
  input  wire logic                     byte_valid,
  input  wire logic [7:0]               byte_data,
  output logic                          byte_ready,
  output logic                          byte_ack,
  // hardware subaddress pins
  input  wire logic                     hw_subaddr_bit0,
  input  wire logic                     hw_subaddr_bit1,
  input  wire logic                     hw_subaddr_bit2,
  // multiplex phase from the timing generator
  input  wire logic [1:0]               mux_phase,
  // display register and status
  output logic [lcdw_pkg::COLS-1:0]     disp_seg,
  output logic [1:0]                    disp_row,
  output logic [5:0]                    data_pointer,
  output logic [2:0]                    subaddr_count,
  output logic                          writer_idle
);
  //----------------------------------------------------------------------------
  // state
  //----------------------------------------------------------------------------
  typedef struct packed {
    lcdw_pkg::lcdw_fsm_t  fsm;
    lcdw_pkg::lcdw_ram_t  ram;
    logic [5:0]           ptr;
    logic [2:0]           sub;
    logic [7:0]           data;
    logic [3:0]           col;
    logic                 any_match;
    logic                 ack;
    logic                 in_bank;
    logic                 out_bank;
    logic [2:0]           hw_meta;
    logic [2:0]           hw_sub;
    logic [lcdw_pkg::COLS-1:0] disp;
    logic [1:0]           row;
  } lcdw_st_t;

  lcdw_st_t                  st;
  lcdw_st_t                  next_st;
  logic                      cmd_any;
  logic                      take;
  logic                      step;
  logic                      match;
  logic                      bank_on;
  logic [1:0]                row_base;
  logic [3:0]                steps;
  logic [2:0]                nbits;
  logic                      f_valid;
  logic [7:0]                f_data;
  logic [1:0]                row_sel;
  logic [lcdw_pkg::COLS-1:0] seg_row;
  logic [lcdw_pkg::COLS-1:0] row0_vec;
  logic [lcdw_pkg::COLS-1:0] row2_vec;

  //----------------------------------------------------------------------------
  // byte buffer
  //----------------------------------------------------------------------------
  lcdw_fifo #(
    .WIDTH (lcdw_pkg::BYTE_W),
    .DEPTH (lcdw_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (byte_valid),
    .in_data   (byte_data),
    .in_ready  (byte_ready),
    .out_valid (f_valid),
    .out_data  (f_data),
    .out_ready (take)
  );

  //----------------------------------------------------------------------------
  // output row selection
  //----------------------------------------------------------------------------
  lcdw_outsel u_outsel (
    .mode     (drive_mode),
    .out_bank (st.out_bank),
    .phase    (mux_phase),
    .ram      (st.ram),
    .row_sel  (row_sel),
    .seg_row  (seg_row)
  );

  //----------------------------------------------------------------------------
  // mode decode
  //----------------------------------------------------------------------------
  always_comb begin
    case (drive_mode)
      lcdw_pkg::LCDW_STATIC: begin
        steps = lcdw_pkg::STEP_STAT;
        nbits = 3'h1;
      end
      lcdw_pkg::LCDW_MUX2: begin
        steps = lcdw_pkg::STEP_MUX2;
        nbits = 3'h2;
      end
      lcdw_pkg::LCDW_MUX3: begin
        steps = lcdw_pkg::STEP_MUX3;
        nbits = 3'h3;
      end
      lcdw_pkg::LCDW_MUX4: begin
        steps = lcdw_pkg::STEP_MUX4;
        nbits = 3'h4;
      end
      default: begin
        steps = lcdw_pkg::STEP_STAT;
        nbits = 3'h1;
      end
    endcase
  end

  // bank switching exists only in static and 1:2
  assign bank_on  = (drive_mode == lcdw_pkg::LCDW_STATIC) || (drive_mode == lcdw_pkg::LCDW_MUX2);
  assign row_base = (bank_on && st.in_bank) ? lcdw_pkg::BANK1_ROW : lcdw_pkg::BANK0_ROW;

  // a command stalls the writer for one cycle so the two never collide
  assign cmd_any = cmd.load_ptr || cmd.dev_sel || cmd.bank_sel;
  assign take    = (st.fsm == lcdw_pkg::LCDW_IDLE) && f_valid && !cmd_any;
  assign step    = (st.fsm == lcdw_pkg::LCDW_WRITE) && !cmd_any;
  assign match   = (st.sub == st.hw_sub);

  //----------------------------------------------------------------------------
  // next state
  //----------------------------------------------------------------------------
  always_comb begin
    int bi;
    bi      = 0;
    next_st = st;
    next_st.ack = 1'b0;
    // pins come from outside the clock domain; the first stage feeds only the second
    next_st.hw_meta = {hw_subaddr_bit2, hw_subaddr_bit1, hw_subaddr_bit0};
    next_st.hw_sub  = st.hw_meta;
    next_st.disp = seg_row;
    next_st.row  = row_sel;

    if (cmd.load_ptr) begin
      next_st.ptr = cmd.ptr_value;
    end
    if (cmd.dev_sel) begin
      next_st.sub = cmd.subaddr;
    end
    if (cmd.bank_sel) begin
      next_st.in_bank  = cmd.in_bank;
      next_st.out_bank = cmd.out_bank;
    end

    case (st.fsm)
      lcdw_pkg::LCDW_IDLE: begin
        if (take) begin
          next_st.fsm       = lcdw_pkg::LCDW_WRITE;
          next_st.data      = f_data;
          next_st.col       = 4'h0;
          next_st.any_match = 1'b0;
        end
      end
      lcdw_pkg::LCDW_WRITE: begin
        if (step) begin
          // one ram column per cycle, msb first into the lowest row of the bank
          for (int r = 0; r < lcdw_pkg::ROWS; r++) begin
            bi = 7 - int'(st.col) * int'(nbits) - r;
            // in 1:3 the third column runs out of bits, so its row 2 is kept
            if (r < int'(nbits) && bi >= 0 && match) begin
              next_st.ram[st.ptr][2'(int'(row_base) + r)] = st.data[3'(bi)];
            end
          end
          next_st.any_match = st.any_match || match;
          // pointer moves whether or not this device stored the column
          if (st.ptr == lcdw_pkg::LAST_COL) begin
            next_st.ptr = 6'h00;
            next_st.sub = st.sub + 3'h1;
          end else begin
            next_st.ptr = st.ptr + 6'h01;
          end
          next_st.col = st.col + 4'h1;
          if (st.col == steps - 4'h1) begin
            next_st.fsm = lcdw_pkg::LCDW_IDLE;
            // a device that stored none of the byte stays silent
            next_st.ack = st.any_match || match;
          end
        end
      end
      default: begin
        next_st.fsm = lcdw_pkg::LCDW_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st     <= '0;
      st.ptr <= lcdw_pkg::PTR_RST;
      st.sub <= lcdw_pkg::SUB_RST;
    end else if (ce) begin
      st <= next_st;
    end
  end

  //----------------------------------------------------------------------------
  // outputs
  //----------------------------------------------------------------------------
  assign byte_ack      = st.ack;
  assign disp_seg      = st.disp;
  assign disp_row      = st.row;
  assign data_pointer  = st.ptr;
  assign subaddr_count = st.sub;
  assign writer_idle   = (st.fsm == lcdw_pkg::LCDW_IDLE);

  //----------------------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------------------
  for (genvar c = 0; c < lcdw_pkg::COLS; c++) begin : g_rowvec
    assign row0_vec[c] = st.ram[c][0];
    assign row2_vec[c] = st.ram[c][2];
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_take;
    ce && take;
  endsequence

  sequence s_step;
    ce && step;
  endsequence

  sequence s_take_static;
    s_take and (drive_mode == lcdw_pkg::LCDW_STATIC);
  endsequence

  sequence s_take_mux4;
    s_take and (drive_mode == lcdw_pkg::LCDW_MUX4);
  endsequence

  a_ptr_load: assert property (ce && cmd.load_ptr |=> st.ptr == $past(cmd.ptr_value))
    else $error("pointer not loaded by command");

  a_subaddr_set: assert property (ce && cmd.dev_sel |=> st.sub == $past(cmd.subaddr))
    else $error("subaddress counter not set by device select");

  a_wrap_subaddr: assert property (s_step and (st.ptr == lcdw_pkg::LAST_COL)
    |=> st.ptr == 6'h00 && st.sub == $past(st.sub) + 3'h1)
    else $error("overflow did not wrap pointer and bump subaddress");

  a_no_store_mismatch: assert property (s_step and !match
    |=> st.ram == $past(st.ram) && st.ptr != $past(st.ptr))
    else $error("mismatched device stored data or held pointer");

  a_mux3_row2_kept: assert property (s_step and (drive_mode == lcdw_pkg::LCDW_MUX3) and (st.col == 4'h2)
    |=> row2_vec == $past(row2_vec))
    else $error("third column row 2 changed in 1:3");

  a_in_bank_rows: assert property (s_step and (drive_mode == lcdw_pkg::LCDW_STATIC) and st.in_bank
    |=> row0_vec == $past(row0_vec))
    else $error("input bank 1 wrote row 0");

  a_static_length: assert property (s_take_static ##1 s_step [*8] |=> writer_idle && byte_ack == $past(st.any_match || match))
    else $error("static byte did not end after eight columns");

  a_static_busy: assert property (s_take_static ##1 s_step [*7] |-> !writer_idle)
    else $error("static byte ended early");

  a_mux4_length: assert property (s_take_mux4 ##1 s_step [*2] |=> writer_idle)
    else $error("1:4 byte did not end after two columns");

  a_ack_pulse: assert property (ce && byte_ack |=> !byte_ack)
    else $error("acknowledge longer than one cycle");

  a_out_row_static: assert property ((drive_mode == lcdw_pkg::LCDW_STATIC) |-> row_sel == (st.out_bank ? 2'h2 : 2'h0))
    else $error("static output row wrong for bank");

  a_out_row_mux4: assert property ((drive_mode == lcdw_pkg::LCDW_MUX4) |-> row_sel == mux_phase)
    else $error("1:4 output row does not follow phase");
endmodule

//--- tb/lcdw_master_model.sv
// bus master model: command strobes and display byte pushes
`timescale 1ns/1ps
module lcdw_master_model (
  // clock
  input  wire logic           sys_clk,
  // commands and display bytes
  output lcdw_pkg::lcdw_cmd_t cmd,
  output logic                byte_valid,
  output logic [7:0]          byte_data,
  input  wire logic           byte_ready
);
  initial begin
    cmd = '0;
    byte_valid = 1'b0;
    byte_data = 8'h00;
  end

  // holding a strobe high repeats the command every cycle, which stalls the writer
  task automatic set_cmd(input lcdw_pkg::lcdw_cmd_t c);
    @(posedge sys_clk);
    cmd <= c;
  endtask

  // the command is driven for one cycle, then every strobe is cleared again
  task automatic send(input lcdw_pkg::lcdw_cmd_t c);
    set_cmd(c);
    set_cmd('0);
  endtask

  // data is held until ready is seen at an edge, then shows its inverse
  task automatic push(input logic [7:0] b, output bit ok);
    bit rdy;
    ok = 1'b0;
    @(posedge sys_clk);
    byte_valid <= 1'b1;
    byte_data <= b;
    for (int i = 0; i < 300 && !ok; i++) begin
      @(negedge sys_clk);
      rdy = byte_ready;
      @(posedge sys_clk);
      ok = rdy;
    end
    byte_valid <= 1'b0;
    byte_data <= ~b;
  endtask
endmodule

//--- tb/lcdw_ram_writer_test.sv
// self-checking bench for the display ram write addressing block
`timescale 1ns/1ps
module lcdw_ram_writer_test;
  //----------------------------------------
  // signals and reference ram image
  //----------------------------------------
  logic                 sys_clk;
  logic                 rst;
  logic                 ce;
  lcdw_pkg::lcdw_cmd_t  cmd;
  lcdw_pkg::lcdw_cmd_t  c;
  lcdw_pkg::lcdw_mode_t drive_mode;
  logic                 byte_valid;
  logic                 byte_ready;
  logic                 byte_ack;
  logic                 writer_idle;
  logic [7:0]           byte_data;
  logic [2:0]           hw;
  logic [2:0]           subaddr_count;
  logic [1:0]           mux_phase;
  logic [1:0]           disp_row;
  logic [39:0]          disp_seg;
  logic [5:0]           data_pointer;
  logic [3:0]           ram [40];
  int                   miscompares;
  int                   total_checks;
  int                   ptr;
  int                   sub;
  int                   n;
  logic                 inb;
  bit                   ok;

  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;

  lcdw_ram_writer lcdw_ram_writer_inst (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .cmd(cmd), .drive_mode(drive_mode),
    .byte_valid(byte_valid), .byte_data(byte_data), .byte_ready(byte_ready), .byte_ack(byte_ack),
    .hw_subaddr_bit0(hw[0]), .hw_subaddr_bit1(hw[1]), .hw_subaddr_bit2(hw[2]),
    .mux_phase(mux_phase), .disp_seg(disp_seg), .disp_row(disp_row),
    .data_pointer(data_pointer), .subaddr_count(subaddr_count), .writer_idle(writer_idle)
  );

  lcdw_master_model lcdw_master_model_inst (
    .sys_clk(sys_clk), .cmd(cmd), .byte_valid(byte_valid), .byte_data(byte_data), .byte_ready(byte_ready)
  );

  //----------------------------------------
  // tasks
  //----------------------------------------
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic fail_out();
    miscompares++;
    stop_test();
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask

  task automatic setm(input lcdw_pkg::lcdw_mode_t m);
    @(posedge sys_clk);
    drive_mode <= m;
  endtask

  // kind 0 load pointer, 1 device select, 2 bank select (v[1] input, v[0] output)
  task automatic issue(input int k, input int v);
    c = '0;
    c.load_ptr = (k == 0);
    c.dev_sel = (k == 1);
    c.bank_sel = (k == 2);
    c.ptr_value = 6'(v);
    c.subaddr = 3'(v);
    c.in_bank = v[1];
    c.out_bank = v[0];
    lcdw_master_model_inst.send(c);
    // let the edge that takes the command settle before anyone looks
    @(negedge sys_clk);
    if (k == 0) ptr = v;
    if (k == 1) sub = v;
    if (k == 2) inb = v[1];
  endtask

  // reference store: w bits per column msb first, pointer wrap carries the subaddress on
  function automatic bit refw(input logic [7:0] b);
    int w;
    int cols;
    bit hit;
    logic [1:0] base;
    w = int'(drive_mode) + 1;
    cols = (w == 3) ? 3 : 8 / w;
    base = (inb && w < 3) ? 2'h2 : 2'h0;
    hit = 1'b0;
    for (int k = 0; k < cols; k++) begin
      if (sub == int'(hw)) begin
        hit = 1'b1;
        for (int j = 0; j < w; j++) begin
          if (7 - k * w - j >= 0) ram[ptr][int'(base) + j] = b[7 - k * w - j];
        end
      end
      ptr = (ptr == 39) ? 0 : ptr + 1;
      if (ptr == 0) sub = (sub + 1) % 8;
    end
    return hit;
  endfunction

  task automatic wr(input logic [7:0] b);
    bit exp_ack;
    bit acked;
    bit busy;
    bit done;
    exp_ack = refw(b);
    lcdw_master_model_inst.push(b, ok);
    {acked, busy, done} = 3'h0;
    for (int i = 0; i < 60 && !done; i++) begin
      @(negedge sys_clk);
      if (byte_ack === 1'b1) acked = 1'b1;
      if (writer_idle === 1'b0) busy = 1'b1;
      else if (busy) done = 1'b1;
    end
    if (!done || !ok) fail_out();
    chk(40'(acked), 40'(exp_ack));
    chk(40'(data_pointer), 40'(ptr));
    chk(40'(subaddr_count), 40'(sub));
  endtask

  task automatic rd_row(input lcdw_pkg::lcdw_mode_t m, input logic [1:0] ph, input int row);
    logic [39:0] e;
    for (int i = 0; i < 40; i++) e[i] = ram[i][row];
    @(posedge sys_clk);
    drive_mode <= m;
    mux_phase <= ph;
    cyc(2);
    @(negedge sys_clk);
    chk(40'(disp_row), 40'(row));
    chk(disp_seg, e);
  endtask

  task automatic rd_all();
    for (int r = 0; r < 4; r++) rd_row(lcdw_pkg::LCDW_MUX4, 2'(r), r);
  endtask

  //----------------------------------------
  // sequence
  //----------------------------------------
  initial begin
    #500_000;
    fail_out();
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    drive_mode = lcdw_pkg::LCDW_STATIC;
    mux_phase = 2'h0;
    hw = 3'h0;
    miscompares = 0;
    total_checks = 0;
    ptr = 0;
    sub = 0;
    inb = 1'b0;
    for (int i = 0; i < 40; i++) ram[i] = 4'h0;
    cyc(2);
    rst <= 1'b0;
    cyc(3);
    chk(40'(data_pointer), 40'h0);
    chk(40'({byte_ready, writer_idle}), 40'h3);
    for (int m = 0; m < 4; m++) begin
      setm(lcdw_pkg::lcdw_mode_t'(m));
      issue(0, 9 * m + 1);
      chk(40'(data_pointer), 40'(ptr));
      wr(8'ha5 ^ 8'(m * 17));
      wr(8'h3c);
    end
    rd_all();
    setm(lcdw_pkg::LCDW_MUX3);
    issue(0, 33);
    wr(8'hff);
    issue(0, 35);
    wr(8'h24);
    rd_all();
    setm(lcdw_pkg::LCDW_STATIC);
    issue(1, 5);
    chk(40'(subaddr_count), 40'h5);
    issue(0, 2);
    wr(8'hff);
    // pins move only while the bus is idle
    @(posedge sys_clk) hw <= 3'h1;
    cyc(3);
    for (int s = 0; s < 2; s++) begin
      issue(1, s);
      issue(0, 36);
      wr(8'h96);
    end
    rd_all();
    @(posedge sys_clk) hw <= 3'h0;
    cyc(3);
    issue(1, 0);
    issue(2, 2);
    issue(0, 20);
    wr(8'h5a);
    setm(lcdw_pkg::LCDW_MUX2);
    issue(0, 20);
    wr(8'hc3);
    rd_all();
    rd_row(lcdw_pkg::LCDW_STATIC, 2'h0, 0);
    issue(2, 1);
    rd_row(lcdw_pkg::LCDW_STATIC, 2'h0, 2);
    rd_row(lcdw_pkg::LCDW_MUX2, 2'h0, 2);
    rd_row(lcdw_pkg::LCDW_MUX2, 2'h1, 3);
    issue(2, 0);
    rd_row(lcdw_pkg::LCDW_MUX2, 2'h1, 1);
    rd_row(lcdw_pkg::LCDW_MUX3, 2'h2, 2);
    rd_row(lcdw_pkg::LCDW_MUX4, 2'h3, 3);
    // fill the buffer while repeated selects hold the writer, then drain it
    setm(lcdw_pkg::LCDW_MUX4);
    issue(0, 0);
    c = '0;
    c.dev_sel = 1'b1;
    lcdw_master_model_inst.set_cmd(c);
    for (int i = 0; i < 8; i++) begin
      void'(refw(8'(i * 37 + 1)));
      lcdw_master_model_inst.push(8'(i * 37 + 1), ok);
      if (!ok) fail_out();
    end
    @(negedge sys_clk);
    chk(40'(byte_ready), 40'h0);
    lcdw_master_model_inst.set_cmd('0);
    n = 0;
    for (int i = 0; i < 100 && !(n == 8 && writer_idle === 1'b1); i++) begin
      @(negedge sys_clk);
      if (byte_ack === 1'b1) n++;
    end
    chk(40'(n), 40'h8);
    if (n != 8) stop_test();
    chk(40'(data_pointer), 40'(ptr));
    rd_all();
    // a command while the enable is low must leave the pointer alone
    n = ptr;
    @(posedge sys_clk) ce <= 1'b0;
    issue(0, 7);
    chk(40'(data_pointer), 40'(n));
    @(posedge sys_clk) ce <= 1'b1;
    ptr = n;
    stop_test();
  end
endmodule
